// ===== fbsc_defs.vh
// Purpose: Constants for the flash bypass and sector check host controller
// Assumes: x16 flash bus, word addressing
// Notes:   Times in ns, counts in CORE_CLK cycles at 4 ns
`ifndef FBSC_DEFS_VH
`define FBSC_DEFS_VH
`define FBSC_UNLOCK1_ADDR   12'h0555
`define FBSC_UNLOCK2_ADDR   12'h02AA
`define FBSC_UNLOCK1_DATA   16'h00AA
`define FBSC_UNLOCK2_DATA   16'h0055
`define FBSC_BYP_ENTRY      16'h0020
`define FBSC_BYP_PROG       16'h00A0
`define FBSC_BYP_EXIT1      16'h0090
`define FBSC_BYP_EXIT2      16'h0000
`define FBSC_EES_CMD        16'h0035
`define FBSC_BLANK_CMD      16'h0033
`define FBSC_SR_READ_CMD    16'h0070
`define FBSC_SR_CLEAR_CMD   16'h0071
`define FBSC_BUF_WRITE_CMD  16'h0025
`define FBSC_BUF_CONF_CMD   16'h0029
`define FBSC_ABORT_RST_CMD  16'h00F0
`define FBSC_SR_READY_BIT   7
`define FBSC_SR_FAIL_BIT    5
`define FBSC_CLK_NS         4
`define FBSC_WE_LOW_NS      40
`define FBSC_RD_ACC_NS      100
`define FBSC_WE_LOW_CYC     ((`FBSC_WE_LOW_NS + `FBSC_CLK_NS - 1) / `FBSC_CLK_NS)
`define FBSC_RD_ACC_CYC     ((`FBSC_RD_ACC_NS + `FBSC_CLK_NS - 1) / `FBSC_CLK_NS)
`endif

// ===== fbsc_bus_cycle.v
// Purpose: One asynchronous flash write or read cycle on the parallel bus
// Assumes: Inputs synchronous to clk; flash data read back after fixed access time
// Notes:   Data pins split into in, out and active-low output enable
`timescale 1ns/1ps
`include "fbsc_defs.vh"
module fbsc_bus_cycle #(
   parameter AW = 26,
   parameter WE_CYC = `FBSC_WE_LOW_CYC,
   parameter RD_CYC = `FBSC_RD_ACC_CYC
) (
   input  wire          clk,
   input  wire          rst_n,
   input  wire          start,
   input  wire          is_write,
   input  wire [AW-1:0] addr,
   input  wire [15:0]   wdata,
   input  wire [15:0]   dq_in,
   output reg           done_ff,
   output reg  [15:0]   rdata_ff,
   output reg  [AW-1:0] a_ff,
   output reg  [15:0]   dq_out_ff,
   output reg           dq_oe_n_ff,
   output reg           ce_n_ff,
   output reg           we_n_ff,
   output reg           oe_n_ff
);
   reg [7:0] cnt_ff;
   reg       busy_ff;
   // Strobe timing; one cycle holds address past the strobe edge
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff     <= 8'h00;
         busy_ff    <= 1'b0;
         done_ff    <= 1'b0;
         rdata_ff   <= 16'h0000;
         a_ff       <= {AW{1'b0}};
         dq_out_ff  <= 16'h0000;
         dq_oe_n_ff <= 1'b1;
         ce_n_ff    <= 1'b1;
         we_n_ff    <= 1'b1;
         oe_n_ff    <= 1'b1;
      end else begin
         done_ff <= 1'b0;
         if (!busy_ff) begin
            if (start) begin
               busy_ff    <= 1'b1;
               a_ff       <= addr;
               dq_out_ff  <= wdata;
               dq_oe_n_ff <= ~is_write;
               ce_n_ff    <= 1'b0;
               we_n_ff    <= ~is_write;
               oe_n_ff    <= is_write;
               cnt_ff     <= is_write ? WE_CYC[7:0] : RD_CYC[7:0];
            end
         end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
         end else begin
            // Sample read data before releasing the strobes
            if (!oe_n_ff)
               rdata_ff <= dq_in;
            busy_ff    <= 1'b0;
            done_ff    <= 1'b1;
            ce_n_ff    <= 1'b1;
            we_n_ff    <= 1'b1;
            oe_n_ff    <= 1'b1;
            dq_oe_n_ff <= 1'b1;
         end
      end
   end
endmodule

// ===== fbsc_host.v
// Purpose: Host controller issuing unlock bypass, erase status and blank check sequences
// Assumes: One command at a time; user waits for CMD_DONE before the next
// Notes:   Device registers are reached only through flash command cycles
`timescale 1ns/1ps
`include "fbsc_defs.vh"
module fbsc_host #(
   parameter AW = 26,
   parameter SECT_LSB = 16,
   parameter BUF_MAX = 256
) (
   input  wire          CORE_CLK,
   input  wire          RST_N,
   input  wire          CMD_VALID,
   input  wire [3:0]    CMD_OP,
   input  wire [AW-1:0] CMD_ADDR,
   input  wire [15:0]   CMD_DATA,
   input  wire [8:0]    CMD_COUNT,
   input  wire          DATA_VALID,
   input  wire [15:0]   DQ_IN,
   input  wire          RDY_BUSY,
   input  wire          ACCEL_HV,
   output reg           CMD_READY,
   output reg           DATA_READY,
   output reg           CMD_DONE,
   output reg  [15:0]   RESULT,
   output reg           SECTOR_FAIL,
   output reg           IN_BYPASS,
   output reg  [AW-1:0] FL_ADDR,
   output reg  [15:0]   DQ_OUT,
   output reg           DQ_OE_N,
   output reg           CE_N,
   output reg           WE_N,
   output reg           OE_N
);
   // User operations
   localparam OP_ENTER = 4'h0, OP_PROG = 4'h1, OP_BUF = 4'h2, OP_EXIT = 4'h3;
   localparam OP_EES = 4'h4, OP_BLANK = 4'h5, OP_SRCLR = 4'h6, OP_ABORT = 4'h7;
   localparam OP_READ = 4'h8;
   // States
   localparam S_IDLE = 3'd0, S_SEQ = 3'd1, S_BUF = 3'd2, S_POLL = 3'd3;
   localparam S_SRD = 3'd4, S_FIN = 3'd5;

   reg  [1:0]    rst_sync_ff;
   wire          rst_n = rst_sync_ff[1];
   reg  [2:0]    st_ff;
   reg  [3:0]    op_ff;
   reg  [2:0]    step_ff;
   reg  [AW-1:0] addr_ff;
   reg  [15:0]   data_ff;
   reg  [8:0]    left_ff;
   reg           bypass_ff;
   reg           eac_busy_ff;
   reg           start_ff;
   reg           wr_ff;
   reg  [AW-1:0] baddr_ff;
   reg  [15:0]   bdata_ff;
   wire          bdone;
   wire [15:0]   brdata;
   wire [AW-1:0] pa;
   wire [15:0]   pd;
   wire          poe, pce, pwe, ppoe;

   // Sector base plus a word offset
   function [AW-1:0] sect_off;
      input [AW-1:0] a;
      input [11:0]   off;
      begin
         sect_off = {a[AW-1:SECT_LSB], {SECT_LSB{1'b0}}} | {{(AW-12){1'b0}}, off};
      end
   endfunction

   // Reset release through two flops
   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N)
         rst_sync_ff <= 2'b00;
      else
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end

   fbsc_bus_cycle #(.AW(AW)) u_cyc (
      .clk        (CORE_CLK),
      .rst_n      (rst_n),
      .start      (start_ff),
      .is_write   (wr_ff),
      .addr       (baddr_ff),
      .wdata      (bdata_ff),
      .dq_in      (DQ_IN),
      .done_ff    (bdone),
      .rdata_ff   (brdata),
      .a_ff       (pa),
      .dq_out_ff  (pd),
      .dq_oe_n_ff (poe),
      .ce_n_ff    (pce),
      .we_n_ff    (pwe),
      .oe_n_ff    (ppoe)
   );

   // Pins registered once more so top outputs come from flops
   always @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         FL_ADDR <= {AW{1'b0}};
         DQ_OUT  <= 16'h0000;
         DQ_OE_N <= 1'b1;
         CE_N    <= 1'b1;
         WE_N    <= 1'b1;
         OE_N    <= 1'b1;
      end else begin
         FL_ADDR <= pa;
         DQ_OUT  <= pd;
         DQ_OE_N <= poe;
         CE_N    <= pce;
         WE_N    <= pwe;
         OE_N    <= ppoe;
      end
   end

   // Sequencer: one bus cycle per step, next step on its completion
   always @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= S_IDLE; op_ff <= 4'h0; step_ff <= 3'd0;
         addr_ff <= {AW{1'b0}}; data_ff <= 16'h0000; left_ff <= 9'h000;
         bypass_ff <= 1'b0; eac_busy_ff <= 1'b0;
         start_ff <= 1'b0; wr_ff <= 1'b0;
         baddr_ff <= {AW{1'b0}}; bdata_ff <= 16'h0000;
         CMD_READY <= 1'b0; DATA_READY <= 1'b0; CMD_DONE <= 1'b0;
         RESULT <= 16'h0000; SECTOR_FAIL <= 1'b0; IN_BYPASS <= 1'b0;
      end else begin
         start_ff <= 1'b0;
         CMD_DONE <= 1'b0;
         DATA_READY <= 1'b0;
         IN_BYPASS <= bypass_ff | ACCEL_HV;
         case (st_ff)
         S_IDLE: begin
            CMD_READY <= 1'b1;
            if (CMD_VALID && CMD_READY) begin
               CMD_READY <= 1'b0;
               op_ff <= CMD_OP; addr_ff <= CMD_ADDR;
               data_ff <= CMD_DATA; left_ff <= CMD_COUNT;
               step_ff <= 3'd0;
               // Checks refused while an operation is running or a failed check holds RDY_BUSY low
               if ((CMD_OP == OP_EES || CMD_OP == OP_BLANK) && (eac_busy_ff || !RDY_BUSY))
                  st_ff <= S_FIN;
               // Count past the buffer depth refused, the word loader would stall on it
               else if (CMD_OP == OP_BUF && CMD_COUNT >= BUF_MAX[8:0])
                  st_ff <= S_FIN;
               else
                  st_ff <= S_SEQ;
            end
         end
         S_SEQ: begin
            if (!start_ff && step_ff[0] == 1'b0) begin
               start_ff <= 1'b1;
               wr_ff    <= 1'b1;
               step_ff  <= step_ff | 3'd1;
               case (op_ff)
               OP_ENTER: begin
                  baddr_ff <= (step_ff == 3'd2) ? sect_off(addr_ff, `FBSC_UNLOCK2_ADDR)
                                                : sect_off(addr_ff, `FBSC_UNLOCK1_ADDR);
                  bdata_ff <= (step_ff == 3'd0) ? `FBSC_UNLOCK1_DATA :
                              (step_ff == 3'd2) ? `FBSC_UNLOCK2_DATA : `FBSC_BYP_ENTRY;
               end
               OP_PROG: begin
                  baddr_ff <= addr_ff;
                  bdata_ff <= (step_ff == 3'd0) ? `FBSC_BYP_PROG : data_ff;
               end
               OP_BUF: begin
                  baddr_ff <= addr_ff;
                  bdata_ff <= (step_ff == 3'd0) ? `FBSC_BUF_WRITE_CMD
                                                : {7'h00, left_ff};
               end
               OP_EXIT: begin
                  baddr_ff <= addr_ff;
                  bdata_ff <= (step_ff == 3'd0) ? `FBSC_BYP_EXIT1 : `FBSC_BYP_EXIT2;
               end
               OP_EES, OP_BLANK: begin
                  baddr_ff <= sect_off(addr_ff, `FBSC_UNLOCK1_ADDR);
                  bdata_ff <= (op_ff == OP_EES) ? `FBSC_EES_CMD : `FBSC_BLANK_CMD;
               end
               OP_SRCLR: begin
                  baddr_ff <= addr_ff;
                  bdata_ff <= `FBSC_SR_CLEAR_CMD;
               end
               OP_ABORT: begin
                  baddr_ff <= (step_ff == 3'd2) ? sect_off(addr_ff, `FBSC_UNLOCK2_ADDR)
                                                : sect_off(addr_ff, `FBSC_UNLOCK1_ADDR);
                  bdata_ff <= (step_ff == 3'd0) ? `FBSC_UNLOCK1_DATA :
                              (step_ff == 3'd2) ? `FBSC_UNLOCK2_DATA : `FBSC_ABORT_RST_CMD;
               end
               default: begin // Plain array read
                  wr_ff    <= 1'b0;
                  baddr_ff <= addr_ff;
                  bdata_ff <= 16'h0000;
               end
               endcase
            end else if (bdone) begin
               step_ff <= step_ff + 3'd1;
               case (op_ff)
               OP_ENTER: if (step_ff == 3'd5) begin
                  bypass_ff <= 1'b1;
                  st_ff <= S_FIN;
               end
               OP_ABORT: if (step_ff == 3'd5) st_ff <= S_FIN;
               OP_PROG: if (step_ff == 3'd3) begin
                  eac_busy_ff <= 1'b1;
                  st_ff <= S_POLL;
               end
               OP_BUF: if (step_ff == 3'd3) st_ff <= S_BUF;
               OP_EXIT: if (step_ff == 3'd3) begin
                  bypass_ff <= 1'b0;
                  st_ff <= S_FIN;
               end
               OP_EES, OP_BLANK: begin
                  eac_busy_ff <= 1'b1; // flags the check running; gates new checks only, not array reads
                  st_ff <= S_POLL;
               end
               OP_SRCLR: begin
                  SECTOR_FAIL <= 1'b0;
                  st_ff <= S_FIN;
               end
               default: begin
                  RESULT <= brdata;
                  st_ff <= S_FIN;
               end
               endcase
            end
         end
         S_BUF: begin
            // Loads address/data pairs, then confirm; stalls on DATA_VALID
            if (!start_ff && !step_ff[0]) begin
               if (left_ff[8] == 1'b0 || left_ff == 9'h1FF) begin
                  if (left_ff == 9'h1FF) begin
                     start_ff <= 1'b1; wr_ff <= 1'b1; step_ff <= 3'd1;
                     baddr_ff <= addr_ff; bdata_ff <= `FBSC_BUF_CONF_CMD;
                  end else if (DATA_VALID) begin
                     DATA_READY <= 1'b1;
                     start_ff <= 1'b1; wr_ff <= 1'b1; step_ff <= 3'd1;
                     baddr_ff <= CMD_ADDR; bdata_ff <= CMD_DATA;
                  end
               end
            end else if (bdone) begin
               step_ff <= 3'd0;
               if (left_ff == 9'h1FF) begin
                  eac_busy_ff <= 1'b1;
                  st_ff <= S_POLL;
               end else
                  left_ff <= left_ff - 9'h001;
            end
         end
         S_POLL: begin
            // Wait ready via status bit 7 only, RDY_BUSY is not polled; pin stays low on failure
            if (!start_ff && !step_ff[0]) begin
               start_ff <= 1'b1; wr_ff <= 1'b1; step_ff <= 3'd1;
               baddr_ff <= addr_ff; bdata_ff <= `FBSC_SR_READ_CMD;
               st_ff <= S_SRD;
            end
         end
         S_SRD: begin
            if (bdone && wr_ff) begin
               start_ff <= 1'b1; wr_ff <= 1'b0;
            end else if (bdone) begin
               if (brdata[`FBSC_SR_READY_BIT]) begin
                  RESULT <= brdata;
                  // bit 5 carries the failure; host must reerase
                  SECTOR_FAIL <= brdata[`FBSC_SR_FAIL_BIT];
                  eac_busy_ff <= 1'b0;
                  st_ff <= S_FIN;
               end else begin
                  step_ff <= 3'd0;
                  st_ff <= S_POLL;
               end
            end
         end
         default: begin
            // commands are not screened against bypass_ff; any op is issued in bypass
            CMD_DONE <= 1'b1;
            st_ff <= S_IDLE;
         end
         endcase
      end
   end
endmodule

// ===== fbsc_host_monitor.sv
// Purpose: Port checker for the flash bypass and sector check host
// Assumes: One clock domain, RST_N active low
// Notes:   Attached to every host instance by the bind at the foot
`timescale 1ns/1ps
module fbsc_host_monitor #(
   parameter AW = 26
) (
   input wire          CORE_CLK,
   input wire          RST_N,
   input wire          CMD_VALID,
   input wire [3:0]    CMD_OP,
   input wire          CMD_READY,
   input wire          CMD_DONE,
   input wire          DATA_READY,
   input wire          RDY_BUSY,
   input wire          ACCEL_HV,
   input wire          IN_BYPASS,
   input wire [AW-1:0] FL_ADDR,
   input wire [15:0]   DQ_OUT,
   input wire          DQ_OE_N,
   input wire          CE_N,
   input wire          WE_N,
   input wire          OE_N
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   // Bus cycle shape: a write drives data, a read floats it
   strobe_excl_a: assert property (!WE_N |-> OE_N && !CE_N && !DQ_OE_N)
      else $error("Write strobe without select or drive");
   read_float_a: assert property (!OE_N |-> DQ_OE_N && !CE_N && WE_N)
      else $error("Data driven during a read");
   we_width_a: assert property ($fell(WE_N) |-> !WE_N [*8])
      else $error("Write strobe too short");
   write_hold_a: assert property (!WE_N && !$past(WE_N) |-> $stable(FL_ADDR) && $stable(DQ_OUT))
      else $error("Address or data moved under the write strobe");
   // Command handshake and completion
   take_drop_a: assert property (CMD_VALID && CMD_READY |=> !CMD_READY)
      else $error("Ready stayed high after a command was taken");
   done_pulse_a: assert property (CMD_DONE |=> !CMD_DONE)
      else $error("Done longer than one cycle");
   word_pulse_a: assert property (DATA_READY |=> !DATA_READY)
      else $error("Word taken twice");
   op_bound_a: assert property (CMD_VALID && CMD_READY |-> ##[1:1000] CMD_DONE)
      else $error("Command never completed");
   // Checks while the device is busy must not reach the bus; high voltage must show as bypass
   refuse_check_a: assert property (CMD_VALID && CMD_READY && !RDY_BUSY
      && (CMD_OP == 4'h4 || CMD_OP == 4'h5) |=> CE_N throughout (##[0:8] CMD_DONE))
      else $error("Check issued to a busy device");
   accel_bypass_a: assert property (ACCEL_HV |-> ##[0:8] IN_BYPASS)
      else $error("Bypass not shown under high voltage");
endmodule

bind fbsc_host fbsc_host_monitor #(.AW(AW)) u_mon (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
   .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_READY(CMD_READY), .CMD_DONE(CMD_DONE),
   .DATA_READY(DATA_READY), .RDY_BUSY(RDY_BUSY), .ACCEL_HV(ACCEL_HV), .IN_BYPASS(IN_BYPASS),
   .FL_ADDR(FL_ADDR), .DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N), .CE_N(CE_N), .WE_N(WE_N), .OE_N(OE_N));

// ===== fbsc_flash_model.sv
// Purpose: Behavioural flash device for the bypass and sector check host
// Assumes: Strobes sampled on clk, which is far faster than any strobe
// Notes:   bad makes the next sector check report a failure
`timescale 1ns/1ps
module fbsc_flash_model #(
   parameter BUSY_CYC = 40
) (
   input  wire        clk,
   input  wire [25:0] a,
   input  wire [15:0] d,
   input  wire        ce_n,
   input  wire        we_n,
   input  wire        oe_n,
   input  wire        bad,
   output wire [15:0] dq,
   output wire        rdy
);
   logic [15:0] mem [int];
   reg [25:0] wa;
   reg [15:0] wd, rd;
   reg [1:0]  un, nu;
   reg        byp, ext, pend, srm, wcn, bufon, stuck, f5, tog, chk, we_q, oe_q;
   integer    left, busy, n_chk, n_rst;
   // Released bus shows the inverse of the last read, never a stale value
   assign dq  = (!ce_n && !oe_n) ? rd : ~rd;
   assign rdy = (busy == 0) && !stuck;
   initial begin
      {un, byp, ext, pend, srm, wcn, bufon, stuck, f5, tog, chk} = 0;
      {we_q, oe_q, left, busy, n_chk, n_rst, rd} = {2'b11, 128'h0, 16'h0000};
   end
   // One accepted write, decoded on the rising write strobe
   task wr(input [25:0] ad, input [15:0] v);
      begin
         nu = 2'b00;
         if (wcn) begin left = v + 1; wcn = 0; end
         else if (left != 0) begin mem[ad] = v; left = left - 1; end
         else if (pend) begin mem[ad] = v; pend = 0; busy = BUSY_CYC; end
         else if (bufon && v == 16'h0029) begin bufon = 0; busy = BUSY_CYC; end
         else if (v == 16'h00AA && ad[11:0] == 12'h0555) nu = 2'b01;
         else if (v == 16'h0055 && ad[11:0] == 12'h02AA && un == 2'b01) nu = 2'b10;
         else if (v == 16'h0020 && ad[11:0] == 12'h0555 && un == 2'b10) byp = 1;
         else if (v == 16'h00A0 && (byp || un == 2'b10)) pend = 1;
         else if (v == 16'h0025 && (byp || un == 2'b10)) {wcn, bufon} = 2'b11;
         else if (v == 16'h0090 && byp) ext = 1;
         else if (v == 16'h0000 && ext) byp = 0;
         else if ((v == 16'h0035 || v == 16'h0033) && ad[11:0] == 12'h0555 && !byp
                  && busy == 0 && !stuck) begin
            busy = BUSY_CYC;
            chk = 1;
            n_chk = n_chk + 1;
         end
         else if (v == 16'h0070) srm = 1;
         else if (v == 16'h0071) {stuck, f5} = 2'b00;
         else if (v == 16'h00F0 && (!byp || un == 2'b10)) begin
            {stuck, f5, bufon} = 3'b000;
            n_rst = n_rst + 1;
         end
         if (v != 16'h0090) ext = 0;
         un = nu;
      end
   endtask
   // Strobe sampling, read data and busy countdown
   always @(posedge clk) begin
      if (!we_n && !ce_n) {wa, wd} = {a, d};
      if (we_n && !we_q) wr(wa, wd);
      if (!oe_n && oe_q && !ce_n) begin
         tog = ~tog;
         if (srm) rd = {8'h00, busy == 0, 1'b0, f5, 5'h00};
         else if (busy != 0) rd = {9'h000, tog, 6'h00};
         else rd = mem.exists(a) ? mem[a] : 16'hFFFF;
         srm = 0;
      end
      {we_q, oe_q} = {we_n, oe_n};
      if (busy != 0) begin
         busy = busy - 1;
         if (busy == 0) {f5, stuck, chk} = {chk & bad, chk & bad, 1'b0};
      end
   end
endmodule

// ===== tb_top.sv
// Purpose: Self-checking bench for the flash bypass and sector check host
// Assumes: Flash model answers promptly; random data from a fixed seed
// Notes:   Inputs change at the falling edge only
`timescale 1ns/1ps
module tb_top;
   reg         clk, rst_n, cmd_valid, data_valid, accel_hv, bad;
   reg [3:0]   cmd_op;
   reg [25:0]  cmd_addr, ad;
   reg [15:0]  cmd_data, dt;
   reg [8:0]   cmd_count, wc;
   reg [31:0]  rnd;
   wire [25:0] fl_addr;
   wire [15:0] dq_in, dq_out, result;
   wire        rdy_busy, cmd_ready, data_ready, cmd_done, sector_fail, in_bypass;
   wire        dq_oe_n, ce_n, we_n, oe_n;
   integer     miscompares, n_compared, i, n0;
   fbsc_host DUT (.CORE_CLK(clk), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
      .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .CMD_COUNT(cmd_count),
      .DATA_VALID(data_valid), .DQ_IN(dq_in), .RDY_BUSY(rdy_busy), .ACCEL_HV(accel_hv),
      .CMD_READY(cmd_ready), .DATA_READY(data_ready), .CMD_DONE(cmd_done), .RESULT(result),
      .SECTOR_FAIL(sector_fail), .IN_BYPASS(in_bypass), .FL_ADDR(fl_addr), .DQ_OUT(dq_out),
      .DQ_OE_N(dq_oe_n), .CE_N(ce_n), .WE_N(we_n), .OE_N(oe_n));
   fbsc_flash_model m (.clk(clk), .a(fl_addr), .d(dq_out), .ce_n(ce_n), .we_n(we_n),
      .oe_n(oe_n), .bad(bad), .dq(dq_in), .rdy(rdy_busy));
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   // Word k of a buffer load, shared by stimulus and expectation
   function [15:0] buf_word(input [15:0] base, input [8:0] k);
      buf_word = base + {7'h00, k};
   endfunction
   task give_verdict;
      begin
         $display("Compared %0d, mismatches %0d", n_compared, miscompares);
         if (miscompares == 0 && n_compared > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task chk(input [15:0] e, input [15:0] g);
      begin
         n_compared = n_compared + 1;
         if (g !== e) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
         end
      end
   endtask
   task chkb(input e, input g);
      chk({15'h0000, e}, {15'h0000, g});
   endtask
   // One user command; buffer words follow the word-taken pulses
   task do_op(input [3:0] op, input [25:0] a2, input [15:0] d2, input [8:0] w2);
      integer t, k;
      begin
         t = 0;
         k = 0;
         @(negedge clk);
         while (cmd_ready !== 1'b1 && t < 200) begin
            @(negedge clk);
            t = t + 1;
         end
         // Ready never came: go straight to the timeout report
         if (t >= 200)
            t = 20000;
         {cmd_op, cmd_addr, cmd_data, cmd_count} = {op, a2, d2, w2};
         cmd_valid = 1;
         data_valid = (op == 4'h2);
         while (t < 20000) begin
            @(negedge clk);
            t = t + 1;
            if (cmd_ready !== 1'b1) cmd_valid = 0;
            if (data_ready === 1'b1) begin
               k = k + 1;
               cmd_addr = a2 + k[25:0];
               cmd_data = buf_word(d2, k[8:0]);
               data_valid = (k <= w2);
            end
            if (cmd_done === 1'b1) t = 30000;
         end
         if (t < 30000) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, 1'b1, cmd_done);
            give_verdict;
         end
      end
   endtask
   // Main sequence
   initial begin
      {miscompares, n_compared} = 0;
      {rst_n, cmd_valid, data_valid, accel_hv, bad, cmd_op} = 0;
      {cmd_addr, cmd_data, cmd_count} = 0;
      i = $urandom(32'hE668_49B3);
      repeat (3) @(negedge clk);
      chkb(1'b1, ce_n & we_n & oe_n & dq_oe_n);
      rst_n = 1;
      do_op(4'h0, 26'h000_0000, 16'h0000, 9'h000);
      chkb(1'b1, in_bypass);
      chkb(1'b1, m.byp);
      // Random single-word programs in bypass, read back
      for (i = 0; i < 3; i = i + 1) begin
         rnd = $urandom;
         ad = rnd[25:0];
         rnd = $urandom;
         dt = rnd[15:0];
         do_op(4'h1, ad, dt, 9'h000);
         do_op(4'h8, ad, 16'h0000, 9'h000);
         chk(dt, result);
      end
      // Buffer loads of one word and of a random length
      for (i = 0; i < 2; i = i + 1) begin
         // Start on a page boundary so the load stays inside one buffer line
         rnd = $urandom;
         ad = {rnd[25:8], 8'h00};
         rnd = $urandom;
         dt = rnd[15:0];
         rnd = $urandom_range(3, 1);
         wc = i ? rnd[8:0] : 9'h000;
         do_op(4'h2, ad, dt, wc);
         do_op(4'h8, ad + wc, 16'h0000, 9'h000);
         chk(buf_word(dt, wc), result);
      end
      // Count beyond the buffer depth is refused without any bus cycle
      do_op(4'h2, ad, dt, 9'h100);
      chkb(1'b0, m.bufon);
      n0 = m.n_rst;
      do_op(4'h7, ad, 16'h0000, 9'h000);
      chk(n0 + 1, m.n_rst);
      do_op(4'h3, ad, 16'h0000, 9'h000);
      chkb(1'b0, in_bypass);
      chkb(1'b0, m.byp);
      // Both checks, passing and failing, with a refused retry on failure
      for (i = 0; i < 4; i = i + 1) begin
         bad = i[1];
         rnd = $urandom;
         ad = rnd[25:0];
         n0 = m.n_chk;
         do_op(4'h4 + i[0], ad, 16'h0000, 9'h000);
         chk(n0 + 1, m.n_chk);
         chkb(bad, sector_fail);
         chkb(bad, result[5]);
         chkb(1'b1, result[7]);
         chkb(!bad, rdy_busy);
         if (bad) begin
            do_op(4'h4 + i[0], ad, 16'h0000, 9'h000);
            chk(n0 + 1, m.n_chk);
         end
         do_op(4'h6, ad, 16'h0000, 9'h000);
         chkb(1'b0, sector_fail);
         chkb(1'b1, rdy_busy);
      end
      @(negedge clk);
      accel_hv = 1;
      repeat (10) @(negedge clk);
      chkb(1'b1, in_bypass);
      give_verdict;
   end
endmodule
